// ---- verilog/sebfe_defs.vh ----
// Constants for the two-wire serial EEPROM bus front end
// How it works
// - Data line is only ever pulled low; released otherwise for wired-OR sharing.
// - Data sampled on clock rise; outgoing data changes after clock fall.
// - Write-lock pin high blocks every array write; low allows normal operation.
// - 2K variant: 32 pages of 8 bytes, 8-bit word address.
// - 4K variant: 32 pages of 16 bytes, 9-bit word address.
// - 8K variant: 64 pages of 16 bytes, 10-bit word address.
// - 16K variant: 128 pages of 16 bytes, 11-bit word address.
// - Data changes only with clock low; changes with clock high are start/stop.
// - Data falling with clock high is a start; master starts every command.
// - Data rising with clock high is a stop; stop after read gives standby.
// - Standby at power-up and after stop once internal work has finished.
// - Eight-bit words; device pulls data low in ninth clock to acknowledge.
// - Device address word top four bits carry the fixed 1010 family prefix.
// - 2K variant compares three select bits with the three select pins.
// - 4K variant compares two upper select bits; third is a page bit.
// - 8K variant compares top select bit; next two are page bits.
// - 16K variant ignores select pins; all three bits are page bits.
// - Eighth address bit selects direction: high read, low write.
// - Match acknowledges with zero; mismatch gives no acknowledge and standby.
// - Address word is not acknowledged while an internal write cycle runs.
`ifndef SEBFE_DEFS_VH
`define SEBFE_DEFS_VH

// Device address prefix
`define SEBFE_FAMILY     4'hA
// Bits in one word
`define SEBFE_WORD_BITS  4'h8
// Variant codes
`define SEBFE_VAR_2K     2'h0
`define SEBFE_VAR_4K     2'h1
`define SEBFE_VAR_8K     2'h2
`define SEBFE_VAR_16K    2'h3
// Page offset masks
`define SEBFE_PMASK_8    11'h007
`define SEBFE_PMASK_16   11'h00F
// Full address mask of the largest variant
`define SEBFE_AMASK_MAX  11'h7FF
// Reset level of the synchronised pins
`define SEBFE_PIN_RST    6'h3F
// Transfer phases
`define SEBFE_PH_DEV     2'h0
`define SEBFE_PH_WORD    2'h1
`define SEBFE_PH_DATA    2'h2

`endif

// ---- verilog/sebfe_top.v ----
// Two-wire serial EEPROM bus front end, target side
`timescale 1ns/100ps
`include "sebfe_defs.vh"

module sebfe_top #(
  parameter [1:0] VARIANT = `SEBFE_VAR_2K
) (
  input  wire        clk_sys_in,
  input  wire        nrst_in,
  input  wire        scl_in,
  input  wire        sda_in,
  output wire        sda_out,
  output wire        sda_oe_n_out,
  input  wire        chip_select_bit_low_in,
  input  wire        chip_select_bit_mid_in,
  input  wire        chip_select_bit_high_in,
  input  wire        write_lock_in,
  input  wire        busy_in,
  input  wire [7:0]  rd_data_in,
  output wire [10:0] rd_addr_out,
  output wire [10:0] wr_addr_out,
  output wire [7:0]  wr_data_out,
  output wire        wr_stb_out,
  output wire        commit_out,
  output wire        standby_out
);

  // Variant geometry
  localparam [10:0] PMASK = (VARIANT == `SEBFE_VAR_2K) ? `SEBFE_PMASK_8
                                                       : `SEBFE_PMASK_16;
  localparam [10:0] AMASK = `SEBFE_AMASK_MAX >> (2'h3 - VARIANT);
  localparam [2:0]  SEL   = 3'h7 << VARIANT;

  // One-hot states
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_RX   = 5'h02;
  localparam [4:0] ST_ACK  = 5'h04;
  localparam [4:0] ST_TX   = 5'h08;
  localparam [4:0] ST_MACK = 5'h10;

  // Pin synchronisers
  wire [5:0] pin_raw;
  reg  [5:0] s1_q;
  reg  [5:0] s2_q;
  reg  [5:0] s3_q;
  reg  [5:0] flt_q;

  assign pin_raw = {write_lock_in, chip_select_bit_high_in, chip_select_bit_mid_in,
                    chip_select_bit_low_in, sda_in, scl_in};

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_sync
      always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
          s1_q[gi]  <= 1'b1;
          s2_q[gi]  <= 1'b1;
          s3_q[gi]  <= 1'b1;
          flt_q[gi] <= 1'b1;
        end else begin
          s1_q[gi] <= pin_raw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi]) begin
            flt_q[gi] <= s3_q[gi];
          end
        end
      end
    end
  endgenerate

  wire       scl_f  = flt_q[0];
  wire       sda_f  = flt_q[1];
  wire [2:0] cs_f   = flt_q[4:2];
  wire       lock_f = flt_q[5];

  reg scl_p_q;
  reg sda_p_q;

  // Bus events
  wire scl_rise = scl_f & ~scl_p_q;
  wire scl_fall = ~scl_f & scl_p_q;
  wire start_ev = scl_f & scl_p_q & sda_p_q & ~sda_f;
  wire stop_ev  = scl_f & scl_p_q & ~sda_p_q & sda_f;

  // Protocol state
  reg [4:0]  st_q;
  reg [3:0]  cnt_q;
  reg [7:0]  sh_q;
  reg [1:0]  ph_q;
  reg        rd_q;
  reg [2:0]  pg_q;
  reg [10:0] addr_q;
  reg        wrote_q;
  reg        oe_n_q;
  reg        sda_o_q;
  reg [10:0] wr_addr_q;
  reg [7:0]  wr_data_q;
  reg        wr_stb_q;
  reg        commit_q;
  reg        standby_q;

  wire [10:0] addr_inc = addr_q + 11'h001;
  wire [10:0] addr_pg  = (addr_q & ~PMASK) | (addr_inc & PMASK);
  wire [10:0] addr_rd  = addr_inc & AMASK;
  wire [10:0] addr_wd  = ({pg_q, 8'h00} | {3'h0, sh_q}) & AMASK;
  wire        dev_ok   = (sh_q[7:4] == `SEBFE_FAMILY) &&
                         (((sh_q[3:1] ^ cs_f) & SEL) == 3'h0) &&
                         !busy_in;

  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      scl_p_q   <= 1'b1;
      sda_p_q   <= 1'b1;
      st_q      <= ST_IDLE;
      cnt_q     <= 4'h0;
      sh_q      <= 8'h00;
      ph_q      <= `SEBFE_PH_DEV;
      rd_q      <= 1'b0;
      pg_q      <= 3'h0;
      addr_q    <= 11'h000;
      wrote_q   <= 1'b0;
      oe_n_q    <= 1'b1;
      sda_o_q   <= 1'b0;
      wr_addr_q <= 11'h000;
      wr_data_q <= 8'h00;
      wr_stb_q  <= 1'b0;
      commit_q  <= 1'b0;
      standby_q <= 1'b1;
    end else begin
      scl_p_q   <= scl_f;
      sda_p_q   <= sda_f;
      sda_o_q   <= 1'b0;
      wr_stb_q  <= 1'b0;
      commit_q  <= 1'b0;
      standby_q <= (st_q == ST_IDLE) && !busy_in;
      if (start_ev) begin
        st_q   <= ST_RX;
        cnt_q  <= 4'h0;
        ph_q   <= `SEBFE_PH_DEV;
        oe_n_q <= 1'b1;
      end else if (stop_ev) begin
        st_q     <= ST_IDLE;
        oe_n_q   <= 1'b1;
        commit_q <= wrote_q & ~lock_f;
        wrote_q  <= 1'b0;
      end else begin
        case (st_q)
          ST_IDLE: begin
            oe_n_q <= 1'b1;
          end
          ST_RX: begin
            if (scl_rise) begin
              sh_q  <= {sh_q[6:0], sda_f};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == `SEBFE_WORD_BITS) begin
              cnt_q <= 4'h0;
              case (ph_q)
                `SEBFE_PH_DEV: begin
                  if (dev_ok) begin
                    oe_n_q <= 1'b0;
                    st_q   <= ST_ACK;
                    rd_q   <= sh_q[0];
                    pg_q   <= sh_q[3:1] & ~SEL;
                  end else begin
                    st_q <= ST_IDLE;
                  end
                end
                `SEBFE_PH_WORD: begin
                  addr_q <= addr_wd;
                  ph_q   <= `SEBFE_PH_DATA;
                  oe_n_q <= 1'b0;
                  st_q   <= ST_ACK;
                end
                default: begin
                  wr_addr_q <= addr_q;
                  wr_data_q <= sh_q;
                  wr_stb_q  <= ~lock_f;
                  wrote_q   <= 1'b1;
                  addr_q    <= addr_pg;
                  oe_n_q    <= 1'b0;
                  st_q      <= ST_ACK;
                end
              endcase
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (ph_q == `SEBFE_PH_DEV && rd_q) begin
                sh_q   <= rd_data_in;
                oe_n_q <= rd_data_in[7];
                cnt_q  <= 4'h1;
                addr_q <= addr_rd;
                st_q   <= ST_TX;
              end else begin
                oe_n_q <= 1'b1;
                cnt_q  <= 4'h0;
                st_q   <= ST_RX;
                if (ph_q == `SEBFE_PH_DEV) begin
                  ph_q <= `SEBFE_PH_WORD;
                end
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (cnt_q == `SEBFE_WORD_BITS) begin
                oe_n_q <= 1'b1;
                st_q   <= ST_MACK;
              end else begin
                sh_q   <= {sh_q[6:0], 1'b0};
                oe_n_q <= sh_q[6];
                cnt_q  <= cnt_q + 4'h1;
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              st_q <= sda_f ? ST_IDLE : ST_ACK;
            end
          end
          default: begin
            st_q   <= ST_IDLE;
            oe_n_q <= 1'b1;
          end
        endcase
      end
    end
  end

  assign sda_out      = sda_o_q;
  assign sda_oe_n_out = oe_n_q;
  assign rd_addr_out  = addr_q;
  assign wr_addr_out  = wr_addr_q;
  assign wr_data_out  = wr_data_q;
  assign wr_stb_out   = wr_stb_q;
  assign commit_out   = commit_q;
  assign standby_out  = standby_q;

endmodule // sebfe_top

// ---- verif/sebfe_chk_sva.sv ----
// Port checker for the bus front end
`timescale 1ns/100ps
module sebfe_chk (
  input wire        clk_sys_in,
  input wire        nrst_in,
  input wire        scl_in,
  input wire        write_lock_in,
  input wire        busy_in,
  input wire        sda_out,
  input wire        sda_oe_n_out,
  input wire        wr_stb_out,
  input wire [10:0] wr_addr_out,
  input wire [7:0]  wr_data_out,
  input wire        commit_out,
  input wire        standby_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  a_drain_only: assert property (!sda_out)
    else $error("sda high");
  a_oe_scl_low: assert property ($changed(sda_oe_n_out) |-> !scl_in)
    else $error("sda moved");
  a_lock_no_stb: assert property (write_lock_in [*6] |-> !wr_stb_out)
    else $error("lock wr");
  a_lock_no_commit: assert property (write_lock_in [*6] |-> !commit_out)
    else $error("lock c");
  a_stb_pulse: assert property (wr_stb_out |=> !wr_stb_out)
    else $error("stb long");
  a_stb_held: assert property (wr_stb_out |=> $stable({wr_addr_out, wr_data_out}))
    else $error("wr moved");
  a_stb_ack: assert property (wr_stb_out |-> ##[0:2] !sda_oe_n_out)
    else $error("no ack");
  a_busy_wake: assert property (busy_in |=> !standby_out)
    else $error("standby busy");
  a_standby_quiet: assert property (standby_out |-> sda_oe_n_out)
    else $error("idle drv");
  a_commit_pulse: assert property (commit_out |=> !commit_out)
    else $error("commit long");
  c_write: cover property (wr_stb_out);
  c_commit: cover property (commit_out);
  c_ack: cover property ($fell(sda_oe_n_out));
endmodule // sebfe_chk
bind sebfe_top sebfe_chk u_chk (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .scl_in(scl_in),
  .write_lock_in(write_lock_in), .busy_in(busy_in), .sda_out(sda_out),
  .sda_oe_n_out(sda_oe_n_out), .wr_stb_out(wr_stb_out), .wr_addr_out(wr_addr_out),
  .wr_data_out(wr_data_out), .commit_out(commit_out), .standby_out(standby_out));

// ---- verif/sebfe_master.sv ----
// Two-wire bus master model
`timescale 1ns/100ps
module sebfe_master (
  input  wire sda_in,
  output reg  scl_out,
  output reg  sda_drv_out
);
  initial begin
    scl_out = 1'b1;
    sda_drv_out = 1'b1;
  end
  // Data set in scl low, sampled in scl high
  task bit_io(input b, output s);
    begin
      #16 sda_drv_out = b;
      #32 scl_out = 1'b1;
      #16 s = sda_in;
      #16 scl_out = 1'b0;
    end
  endtask
  // Low phase as long as a data bit, so the device has let go of its acknowledge
  task start;
    begin
      #16 sda_drv_out = 1'b1;
      #32 scl_out = 1'b1;
      #16 sda_drv_out = 1'b0;
      #16 scl_out = 1'b0;
    end
  endtask
  task stop;
    begin
      #16 sda_drv_out = 1'b0;
      #32 scl_out = 1'b1;
      #16 sda_drv_out = 1'b1;
      #32;
    end
  endtask
  task wbyte(input [7:0] b, output ack);
    integer i;
    reg s;
    begin
      for (i = 7; i >= 0; i = i - 1) bit_io(b[i], s);
      bit_io(1'b1, ack);
    end
  endtask
  task rbyte(input ma, output [7:0] b);
    integer i;
    reg s;
    begin
      for (i = 7; i >= 0; i = i - 1) bit_io(1'b1, b[i]);
      bit_io(ma, s);
    end
  endtask
  task recover;
    integer i;
    reg s;
    begin
      s = 1'b0;
      for (i = 0; i < 9 && !s; i = i + 1) bit_io(1'b1, s);
      start;
    end
  endtask
endmodule // sebfe_master

// ---- verif/tb_top.sv ----
// Testbench of the bus front end
`timescale 1ns/100ps
module tb_top;
  logic        clk_sys_in = 1'b0, nrst_in = 1'b0, write_lock_in = 1'b0, busy_in = 1'b0, a;
  logic [2:0]  sel = 3'h0;
  logic [7:0]  rd_data_in = 8'h00, rb;
  logic [18:0] notes[$];
  wire         scl, sda_drv, sda_out, sda_oe_n_out, wr_stb_out, commit_out, standby_out;
  wire  [10:0] rd_addr_out, wr_addr_out;
  wire  [7:0]  wr_data_out;
  wire         sda = sda_drv & (sda_oe_n_out | sda_out);
  int          bad_count = 0, samples_checked = 0, i;
  always #4 clk_sys_in = ~clk_sys_in;
  sebfe_top dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out), .chip_select_bit_low_in(sel[0]),
    .chip_select_bit_mid_in(sel[1]), .chip_select_bit_high_in(sel[2]),
    .write_lock_in(write_lock_in), .busy_in(busy_in), .rd_data_in(rd_data_in),
    .rd_addr_out(rd_addr_out), .wr_addr_out(wr_addr_out), .wr_data_out(wr_data_out),
    .wr_stb_out(wr_stb_out), .commit_out(commit_out), .standby_out(standby_out));
  sebfe_master m (.sda_in(sda), .scl_out(scl), .sda_drv_out(sda_drv));
  task chk(input string n, input [18:0] e, input [18:0] s);
    samples_checked++;
    if (s !== e) begin
      $display("[ERR] %s exp %h got %h", n, e, s);
      bad_count++;
    end
  endtask
  task final_report;
    $display("checked %0d errors %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(negedge clk_sys_in) if (wr_stb_out === 1'b1) begin
    if (notes.size() == 0) chk("stray strobe", 19'h0, 19'h1);
    else chk("write", notes.pop_front(), {wr_addr_out, wr_data_out});
  end
  task drive(input l, input b);
    @(posedge clk_sys_in) #1;
    write_lock_in = l;
    busy_in = b;
  endtask
  task wr(input [7:0] ad, input [7:0] b0, input [7:0] b1, input nt);
    logic s, c;
    if (nt) notes.push_back({3'h0, ad, b0});
    if (nt) notes.push_back({3'h0, ad[7:3], ad[2:0] + 3'h1, b1});
    m.start;
    m.wbyte({4'hA, sel, 1'b0}, s);
    chk("ack dev", 0, s);
    m.wbyte(ad, s);
    chk("ack word", 0, s);
    m.wbyte(b0, s);
    chk("ack b0", 0, s);
    m.wbyte(b1, s);
    chk("ack b1", 0, s);
    m.stop;
    c = 1'b0;
    for (int k = 0; k < 40; k++) @(negedge clk_sys_in) c = c | commit_out;
    chk("commit", nt, c);
    chk("notes left", 0, notes.size());
  endtask
  initial begin
    #400000 bad_count++;
    final_report;
  end
  initial begin
    rb = $urandom(32'hB431E598);
    sel = $urandom;
    rd_data_in = $urandom;
    repeat (8) @(posedge clk_sys_in);
    #1 nrst_in = 1'b1;
    repeat (8) @(posedge clk_sys_in);
    #1;
    m.recover;
    for (i = 0; i < 4; i++) m.bit_io(1'b1, a);
    wr(8'h07, $urandom, $urandom, 1'b1);
    drive(1'b1, 1'b0);
    wr(8'h20, 8'h55, 8'hAA, 1'b0);
    for (i = 0; i < 3; i++) begin
      drive(1'b0, i == 2);
      m.start;
      m.wbyte(i == 0 ? {4'h5, sel, 1'b0} : {4'hA, sel ^ {i == 1, 2'h0}, 1'b0}, a);
      chk("nack", 1, a);
      m.stop;
    end
    drive(1'b0, 1'b0);
    m.start;
    m.wbyte({4'hA, sel, 1'b0}, a);
    chk("ack dw", 0, a);
    m.wbyte(8'h30, a);
    chk("ack wa", 0, a);
    m.start;
    m.wbyte({4'hA, sel, 1'b1}, a);
    chk("ack rd", 0, a);
    m.rbyte(1'b0, rb);
    chk("read0", rd_data_in, rb);
    m.rbyte(1'b1, rb);
    chk("read1", rd_data_in, rb);
    chk("raddr", 11'h032, rd_addr_out);
    m.stop;
    repeat (10) @(negedge clk_sys_in);
    chk("standby", 1, standby_out);
    final_report;
  end
endmodule // tb_top
